// file: common/gxp_map.svh
// constants of the 16-bit i2c gpio expander: timing, codes, reset values
`ifndef GXP_MAP_SVH
`define GXP_MAP_SVH

`define GXP_CLK_NS      4
`define GXP_GLITCH_NS   8
`define GXP_FILT_CYC    ((`GXP_GLITCH_NS + `GXP_CLK_NS - 1) / `GXP_CLK_NS)
`define GXP_SCL_MAX_KHZ 1000
`define GXP_INIT_CYC    2'h3

// fixed top bit of the 7-bit slave address, value is arbitrary
`define GXP_ADDR_TOP    1'h0

// command byte bits [2:1] pick the bank, bit 0 the port
`define GXP_BANK_IN     2'h0
`define GXP_BANK_OUT    2'h1
`define GXP_BANK_POL    2'h2
`define GXP_BANK_DIR    2'h3

`define GXP_RST_IN      8'h00
`define GXP_RST_OUT     8'hFF
`define GXP_RST_POL     8'h00
`define GXP_RST_DIR     8'hFF

`endif

// file: common/gxp_pkg.sv
// types of the 16-bit i2c gpio expander
package gxp_pkg;

  typedef enum logic [2:0] {
    st_idle  = 3'h0,
    st_addr  = 3'h1,
    st_cmd   = 3'h2,
    st_wdata = 3'h3,
    st_sack  = 3'h4,
    st_rdata = 3'h5,
    st_mack  = 3'h6
  } gxp_state_type;

endpackage

// file: verilog/gxp_glitch_filter.sv
// two-flop synchroniser and spike filter for one bus line
`timescale 1ns/1ps
`default_nettype none
`include "gxp_map.svh"

module gxp_glitch_filter #(
  parameter int FILT_CYC = `GXP_FILT_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_line,
  output logic      o_level
);

  logic [1:0] sync_reg;
  logic [3:0] cnt_reg;

  // lines idle high on an open-drain bus
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      sync_reg <= 2'h3;
    else
      sync_reg <= {sync_reg[0], i_line};
  end

  // a change must hold for FILT_CYC cycles before it is taken
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_reg <= 4'h0;
      o_level <= 1'h1;
    end
    else if (sync_reg[1] == o_level)
      cnt_reg <= 4'h0;
    else if (cnt_reg == 4'(FILT_CYC - 1))
    begin
      cnt_reg <= 4'h0;
      o_level <= sync_reg[1];
    end
    else
      cnt_reg <= cnt_reg + 4'h1;
  end

  a_glitch_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $changed(o_level) |-> ($past(sync_reg[1], 1) == o_level)
                          && ($past(sync_reg[1], 2) == o_level))
    else $error("filtered line changed without a stable input");

endmodule
`default_nettype wire

// file: verilog/gxp_expander.sv
// 16-bit gpio expander behind an i2c slave with open-drain interrupt
`timescale 1ns/1ps
`default_nettype none
`include "gxp_map.svh"

module gxp_expander #(
  parameter int FILT_CYC = `GXP_FILT_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe_n,
  input  wire logic [1:0]  i_addr_strap_0,
  input  wire logic [1:0]  i_addr_strap_1,
  input  wire logic [1:0]  i_addr_strap_2,
  input  wire logic [15:0] i_io_pin,
  output logic [15:0]      o_io_pin,
  output logic [15:0]      o_io_pin_oe_n,
  output logic             o_int_n,
  output logic             o_int_oe_n
);

  gxp_pkg::gxp_state_type state_reg;
  gxp_pkg::gxp_state_type ack_next_reg;
  logic [2:0]  cnt_reg;
  logic [7:0]  shreg_reg;
  logic [2:0]  ptr_reg;
  logic        sda_drv_reg;
  logic        macked_reg;
  logic [1:0]  init_cnt_reg;
  logic        init_done;
  logic [6:0]  my_addr_reg;
  logic [5:0]  strap_s1_reg;
  logic [5:0]  strap_s2_reg;
  logic [15:0] pin_s1_reg;
  logic [15:0] pin_s2_reg;
  logic [7:0]  out_reg [2];
  logic [7:0]  pol_reg [2];
  logic [7:0]  dir_reg [2];
  logic [7:0]  in_reg  [2];
  logic [7:0]  pin_b   [2];
  logic [1:0]  diff;
  logic        int_reg;
  logic        scl_f;
  logic        sda_f;
  logic        scl_q_reg;
  logic        sda_q_reg;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic [7:0]  byte_in;
  logic        wr_stb;
  logic        rd_load;
  logic [7:0]  rd_data;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // bus lines filtered before any protocol logic sees them
  gxp_glitch_filter #(.FILT_CYC(FILT_CYC)) u_scl_filt (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_line    (i_scl),
    .o_level   (scl_f)
  );
  gxp_glitch_filter #(.FILT_CYC(FILT_CYC)) u_sda_filt (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_line    (i_sda),
    .o_level   (sda_f)
  );

  // pins and straps come from outside; two flops before any use
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      pin_s1_reg   <= 16'h0000;
      pin_s2_reg   <= 16'h0000;
      strap_s1_reg <= 6'h00;
      strap_s2_reg <= 6'h00;
    end
    else
    begin
      pin_s1_reg   <= i_io_pin;
      pin_s2_reg   <= pin_s1_reg;
      strap_s1_reg <= {i_addr_strap_2, i_addr_strap_1, i_addr_strap_0};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // short wake-up so synchronisers settle before straps and pins are caught
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      init_cnt_reg <= 2'h0;
      my_addr_reg  <= 7'h00;
    end
    else if (!init_done)
    begin
      init_cnt_reg <= init_cnt_reg + 2'h1;
      if (init_cnt_reg == 2'h2)
        my_addr_reg <= {`GXP_ADDR_TOP, strap_s2_reg};
    end
  end
  assign init_done = (init_cnt_reg == `GXP_INIT_CYC);

  // bus conditions; start and stop only while scl is high
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_q_reg <= 1'h1;
      sda_q_reg <= 1'h1;
    end
    else
    begin
      scl_q_reg <= scl_f;
      sda_q_reg <= sda_f;
    end
  end
  assign scl_rise = scl_f & ~scl_q_reg;
  assign scl_fall = ~scl_f & scl_q_reg;
  assign start_c  = scl_f & scl_q_reg & sda_q_reg & ~sda_f;
  assign stop_c   = scl_f & scl_q_reg & ~sda_q_reg & sda_f;
  assign byte_in  = {shreg_reg[6:0], sda_f};

  // strobes shared by the protocol and the register file
  assign wr_stb  = init_done & scl_rise & (state_reg == gxp_pkg::st_wdata)
                   & (cnt_reg == 3'h7);
  assign rd_load = init_done & scl_fall & (cnt_reg == 3'h1)
                   & (((state_reg == gxp_pkg::st_sack)
                       & (ack_next_reg == gxp_pkg::st_rdata))
                      | ((state_reg == gxp_pkg::st_mack) & macked_reg));

  // per port pin bytes and change detect on pins that are inputs
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    assign pin_b[p] = pin_s2_reg[8*p +: 8];
    assign diff[p]  = |((pin_b[p] ^ in_reg[p]) & dir_reg[p]);
  end

  // read value of the selected register; inputs return the live pins xor polarity
  always_comb
  begin
    case (ptr_reg[2:1])
      `GXP_BANK_IN:  rd_data = pin_b[ptr_reg[0]] ^ pol_reg[ptr_reg[0]];
      `GXP_BANK_OUT: rd_data = out_reg[ptr_reg[0]];
      `GXP_BANK_POL: rd_data = pol_reg[ptr_reg[0]];
      default:       rd_data = dir_reg[ptr_reg[0]];
    endcase
  end

  // i2c slave: sample on scl rise, change sda on scl fall
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg    <= gxp_pkg::st_idle;
      ack_next_reg <= gxp_pkg::st_idle;
      cnt_reg      <= 3'h0;
      shreg_reg    <= 8'h00;
      ptr_reg      <= 3'h0;
      sda_drv_reg  <= 1'h0;
      macked_reg   <= 1'h0;
    end
    else if (!init_done || stop_c)
    begin
      state_reg   <= gxp_pkg::st_idle;
      sda_drv_reg <= 1'h0;
    end
    else if (start_c)
    begin
      state_reg   <= gxp_pkg::st_addr;
      cnt_reg     <= 3'h0;
      sda_drv_reg <= 1'h0;
    end
    else if (scl_rise)
    begin
      cnt_reg <= cnt_reg + 3'h1;
      case (state_reg)
        gxp_pkg::st_addr:
        begin
          shreg_reg <= byte_in;
          if (cnt_reg == 3'h7)
          begin
            if (byte_in[7:1] == my_addr_reg)
            begin
              state_reg    <= gxp_pkg::st_sack;
              ack_next_reg <= byte_in[0] ? gxp_pkg::st_rdata
                                         : gxp_pkg::st_cmd;
            end
            else
              state_reg <= gxp_pkg::st_idle;
          end
        end
        gxp_pkg::st_cmd:
        begin
          shreg_reg <= byte_in;
          if (cnt_reg == 3'h7)
          begin
            ptr_reg      <= byte_in[2:0];
            state_reg    <= gxp_pkg::st_sack;
            ack_next_reg <= gxp_pkg::st_wdata;
          end
        end
        gxp_pkg::st_wdata:
        begin
          shreg_reg <= byte_in;
          if (cnt_reg == 3'h7)
          begin
            ptr_reg      <= ptr_reg ^ 3'h1; // ports of a bank alternate
            state_reg    <= gxp_pkg::st_sack;
            ack_next_reg <= gxp_pkg::st_wdata;
          end
        end
        gxp_pkg::st_rdata:
          if (cnt_reg == 3'h7)
            state_reg <= gxp_pkg::st_mack;
        gxp_pkg::st_mack:
          macked_reg <= ~sda_f;
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (state_reg)
        gxp_pkg::st_sack:
          if (cnt_reg == 3'h0)
            sda_drv_reg <= 1'h1;
          else
          begin
            cnt_reg   <= 3'h0;
            state_reg <= ack_next_reg;
            if (rd_load)
            begin
              shreg_reg   <= rd_data;
              sda_drv_reg <= ~rd_data[7];
              ptr_reg     <= ptr_reg ^ 3'h1;
            end
            else
              sda_drv_reg <= 1'h0;
          end
        gxp_pkg::st_rdata:
        begin
          shreg_reg   <= {shreg_reg[6:0], 1'h0};
          sda_drv_reg <= ~shreg_reg[6];
        end
        gxp_pkg::st_mack:
          if (cnt_reg == 3'h0)
            sda_drv_reg <= 1'h0; // release for the master's ack bit
          else if (rd_load)
          begin
            cnt_reg     <= 3'h0;
            state_reg   <= gxp_pkg::st_rdata;
            shreg_reg   <= rd_data;
            sda_drv_reg <= ~rd_data[7];
            ptr_reg     <= ptr_reg ^ 3'h1;
          end
          else
            state_reg <= gxp_pkg::st_idle; // nack ends the read
        default: ;
      endcase
    end
  end

  // register file; input snapshot taken when the master reads it
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < 2; i++)
      begin
        out_reg[i] <= `GXP_RST_OUT;
        pol_reg[i] <= `GXP_RST_POL;
        dir_reg[i] <= `GXP_RST_DIR;
        in_reg[i]  <= `GXP_RST_IN;
      end
    end
    else if (init_cnt_reg == 2'h2)
    begin
      in_reg[0] <= pin_b[0]; // avoids a false change right after reset
      in_reg[1] <= pin_b[1];
    end
    else if (wr_stb)
    begin
      case (ptr_reg[2:1])
        `GXP_BANK_OUT: out_reg[ptr_reg[0]] <= byte_in;
        `GXP_BANK_POL: pol_reg[ptr_reg[0]] <= byte_in;
        `GXP_BANK_DIR: dir_reg[ptr_reg[0]] <= byte_in;
        default: ; // input registers are read only
      endcase
    end
    else if (rd_load && ptr_reg[2:1] == `GXP_BANK_IN)
      in_reg[ptr_reg[0]] <= pin_b[ptr_reg[0]];
  end

  // interrupt registered so the pin never glitches on comparator skew
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      int_reg <= 1'h0;
    else
      int_reg <= init_done & (|diff);
  end

  assign o_int_n       = 1'h0;
  assign o_int_oe_n    = ~int_reg;
  assign o_sda         = 1'h0;
  assign o_sda_oe_n    = ~sda_drv_reg;
  assign o_io_pin      = {out_reg[1], out_reg[0]};
  assign o_io_pin_oe_n = {dir_reg[1], dir_reg[0]};

  sequence s_dir_write;
    wr_stb && ptr_reg[2:1] == `GXP_BANK_DIR;
  endsequence
  sequence s_out_write;
    wr_stb && ptr_reg[2:1] == `GXP_BANK_OUT && !ptr_reg[0];
  endsequence

  a_reset_inputs: assert property ($past(i_rst) |-> &o_io_pin_oe_n)
    else $error("pin driven right after reset");
  a_dir_update: assert property (s_dir_write |=>
    dir_reg[$past(ptr_reg[0])] == $past(byte_in))
    else $error("direction write not stored");
  a_out_drive: assert property (s_out_write |=>
    o_io_pin[7:0] == $past(byte_in))
    else $error("output write not driven");
  a_pol_read: assert property (rd_load && ptr_reg[2:1] == 2'h0 |=>
    shreg_reg == $past(pin_b[ptr_reg[0]] ^ pol_reg[ptr_reg[0]]))
    else $error("input read ignores polarity");
  a_dir_readback: assert property (rd_load && ptr_reg[2:1] == 2'h3 |=>
    shreg_reg == $past(dir_reg[ptr_reg[0]]) && o_sda_oe_n == shreg_reg[7])
    else $error("direction readback wrong");
  a_int_change: assert property (init_done && (|diff) |=> !o_int_oe_n)
    else $error("change not flagged");
  a_int_open_drain: assert property ((o_int_n == 1'h0)
    && (o_int_oe_n == !$past(init_done & (|diff))))
    else $error("interrupt pin not open drain");
  a_stop_idle: assert property (stop_c |=>
    state_reg == gxp_pkg::st_idle && o_sda_oe_n)
    else $error("stop did not idle the slave");
  a_addr_miss: assert property (init_done && scl_rise && cnt_reg == 3'h7
    && state_reg == gxp_pkg::st_addr && byte_in[7:1] != my_addr_reg
    |=> state_reg == gxp_pkg::st_idle ##1 o_sda_oe_n)
    else $error("foreign address acknowledged");
  a_int_clear: assert property (rd_load && ptr_reg[2:1] == 2'h0
    && !start_c |=> !diff[$past(ptr_reg[0])])
    else $error("read did not clear the change");

endmodule
`default_nettype wire

// file: bench/gxp_i2c_master.sv
// i2c bus master model that drives scl and sda of the expander
`timescale 1ns/1ps
`default_nettype none

module gxp_i2c_master (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda
);
  // open-drain drive: 0 pulls low, 1 releases the line to its pull-up
  initial
  begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end

  // half of the 48 ns bus clock; every change lands on a falling edge
  task automatic half();
    repeat (6) @(negedge i_clk);
  endtask

  // sample in mid-high, well clear of the slave's late data change
  task automatic clk_bit(output logic b);
    half();
    o_scl = 1'h1;
    repeat (3) @(negedge i_clk);
    b = i_sda;
    repeat (3) @(negedge i_clk);
    o_scl = 1'h0;
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic start();
    o_sda = 1'h1;
    half();
    o_scl = 1'h1;
    half();
    o_sda = 1'h0;
    half();
    o_scl = 1'h0;
  endtask

  task automatic stop();
    o_sda = 1'h0;
    half();
    o_scl = 1'h1;
    half();
    o_sda = 1'h1;
    half();
  endtask

  // eight bits msb first, then the slave's acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      o_sda = d[i];
      clk_bit(b);
    end
    o_sda = 1'h1;
    clk_bit(ack);
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic b;
    o_sda = 1'h1;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i]);
    o_sda = nack;
    clk_bit(b);
  endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
// self-checking bench of the 16-bit i2c gpio expander
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [6:0] ADDR = 7'h39;
  typedef struct packed {
    logic [7:0] cmd, d0, d1, e0, e1;
  } gxp_row_type;
  // rows: command, two data bytes written, two bytes read back
  gxp_row_type rows [4] = '{
    '{8'h04, 8'hF0, 8'h0F, 8'hF0, 8'h0F},
    '{8'h02, 8'hA5, 8'h3C, 8'hA5, 8'h3C},
    '{8'h06, 8'h0F, 8'hFF, 8'h0F, 8'hFF},
    '{8'h00, 8'h00, 8'h00, 8'h59, 8'h55}};
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [15:0] ext = 16'h5A69;
  logic        m_scl;
  logic        m_sda;
  logic        sda_w;
  logic        int_w;
  logic        o_sda;
  logic        sda_oe_n;
  logic [15:0] io_o;
  logic [15:0] io_oe_n;
  logic        int_n;
  logic        int_oe_n;
  logic [15:0] pins;
  logic        ack;
  logic [7:0]  r0;
  logic [7:0]  r1;
  int          err_count = 0;
  int          check_count = 0;

  always #2 clk = ~clk;

  // wired levels: pull-ups on sda and int, driven pins follow the port
  assign sda_w = m_sda & (sda_oe_n | o_sda);
  assign int_w = int_oe_n | int_n;
  assign pins  = (io_oe_n & ext) | (~io_oe_n & io_o);

  gxp_i2c_master i_mst (
    .i_clk (clk),
    .i_sda (sda_w),
    .o_scl (m_scl),
    .o_sda (m_sda)
  );

  gxp_expander i_dut (
    .i_clk_sys      (clk),
    .i_rst          (rst),
    .i_scl          (m_scl),
    .i_sda          (sda_w),
    .o_sda          (o_sda),
    .o_sda_oe_n     (sda_oe_n),
    .i_addr_strap_0 (2'h1),
    .i_addr_strap_1 (2'h2),
    .i_addr_strap_2 (2'h3),
    .i_io_pin       (pins),
    .o_io_pin       (io_o),
    .o_io_pin_oe_n  (io_oe_n),
    .o_int_n        (int_n),
    .o_int_oe_n     (int_oe_n)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] c, d0, d1);
    i_mst.start();
    i_mst.wbyte({ADDR, 1'h0}, ack);
    chk(ack, 1'h0);
    i_mst.wbyte(c, ack);
    i_mst.wbyte(d0, ack);
    i_mst.wbyte(d1, ack);
    chk(ack, 1'h0);
    i_mst.stop();
  endtask

  // pointer toggles port after each byte, so one read gives both ports
  task automatic rd(input logic [7:0] c);
    i_mst.start();
    i_mst.wbyte({ADDR, 1'h0}, ack);
    i_mst.wbyte(c, ack);
    i_mst.start();
    i_mst.wbyte({ADDR, 1'h1}, ack);
    i_mst.rbyte(1'h0, r0);
    i_mst.rbyte(1'h1, r1);
    i_mst.stop();
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // cut a hang: the whole sequence needs well under 20000 cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial
  begin
    repeat (16) @(negedge clk);
    chk(io_oe_n, 16'hFFFF);
    chk(io_o, 16'hFFFF);
    chk(int_w, 1'h1);
    rst = 1'h0;
    repeat (12) @(negedge clk);
    for (int i = 0; i < 4; i++)
    begin
      wr(rows[i].cmd, rows[i].d0, rows[i].d1);
      rd(rows[i].cmd);
      chk({r1, r0}, {rows[i].e1, rows[i].e0});
    end
    chk(io_oe_n, 16'hFF0F);
    chk(io_o, 16'h3CA5);
    chk(int_w, 1'h1);
    // an input pin moves away from its captured value
    ext = 16'h5A68;
    repeat (10) @(negedge clk);
    chk(int_w, 1'h0);
    rd(8'h00);
    chk({r1, r0}, 16'h5558);
    chk(int_w, 1'h1);
    ext = 16'h5B68;
    repeat (10) @(negedge clk);
    chk(int_w, 1'h0);
    ext = 16'h5A68;
    repeat (10) @(negedge clk);
    chk(int_w, 1'h1);
    // another strap code must not be answered
    i_mst.start();
    i_mst.wbyte({ADDR ^ 7'h01, 1'h0}, ack);
    chk(ack, 1'h1);
    i_mst.stop();
    // reset in mid-run brings the defaults back
    rst = 1'h1;
    repeat (4) @(negedge clk);
    chk(io_oe_n, 16'hFFFF);
    chk(io_o, 16'hFFFF);
    rst = 1'h0;
    repeat (12) @(negedge clk);
    rd(8'h04);
    chk({r1, r0}, 16'h0000);
    finish_test();
  end
endmodule
`default_nettype wire
